// *** rfl_ctrl.sv ***
// Implementation choice: the plain strobed port.
`default_nettype none
module rfl_ctrl #(
	parameter bit FULL_WIDTH = 1'b1,
	parameter bit ECC_EN = 1'b1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic [3:0] req_rsp_flits,
	output logic request_port_ready,
	input wire logic retry_space_ok,
	input wire logic token_ok,
	input wire logic rsp_valid,
	input wire logic [3:0] rsp_flits,
	input wire logic rspq_ecc_uncorr,
	input wire logic rspq_ecc_corr,
	input wire logic rtry_ecc_uncorr,
	input wire logic rtry_ecc_corr,
	input wire logic mem_fatal_n,
	output logic irq
);
	// ****************
	// Registers
	// ****************
	logic limit_en;
	logic [rfl_pkg::THR_W-1:0] thr_field;
	logic [rfl_pkg::ST_W-1:0] status;
	logic [rfl_pkg::ST_W-1:0] irq_en;
	logic global_en;
	logic [rfl_pkg::CNT_W-1:0] outstanding;
	logic [rfl_pkg::CNT_W-1:0] threshold;
	logic [rfl_pkg::CNT_W-1:0] next_outstanding;
	logic [rfl_pkg::CNT_W-1:0] projected;
	logic [rfl_pkg::ST_W-1:0] events;
	logic [rfl_pkg::ST_W-1:0] clr_mask;
	logic [rfl_pkg::ST_W-1:0] next_status;
	logic req_sent;
	logic over_limit;
	logic wr_limit;
	logic wr_status;
	logic wr_clr;

	assign wr_limit = reg_wr && FULL_WIDTH
		&& (reg_addr == rfl_pkg::ADDR_LIMIT); // R7
	assign wr_status = reg_wr && (reg_addr == rfl_pkg::ADDR_STATUS);
	assign wr_clr = reg_wr && (reg_addr == rfl_pkg::ADDR_IRQ_CLR);

	// ****************
	// Limiter control
	// ****************
	always_ff @(posedge clock) begin
		if (!nrst) begin
			limit_en <= rfl_pkg::RST_LIMIT_EN; // R17
			thr_field <= rfl_pkg::RST_THR; // R17
		end else if (wr_limit) begin
			limit_en <= reg_wdata[rfl_pkg::LIMIT_EN_BIT];
			thr_field <= reg_wdata[rfl_pkg::THR_MSB:rfl_pkg::THR_LSB];
		end
	end

	// Four times the field
	assign threshold = {2'b00, thr_field, 2'b00}; // R2

	// ****************
	// Request gating
	// ****************
	assign projected = outstanding + {8'h00, req_rsp_flits};
	assign over_limit = limit_en && (projected > threshold); // R1
	// Responses are never throttled, client guarantees room
	always_comb begin
		request_port_ready = retry_space_ok && token_ok; // R3
		if (over_limit) begin
			request_port_ready = 1'b0; // R5
		end
	end
	assign req_sent = req_valid && request_port_ready;

	// ****************
	// Outstanding FLIT count
	// ****************
	always_comb begin
		next_outstanding = outstanding;
		if (req_sent) begin
			next_outstanding = next_outstanding + {8'h00, req_rsp_flits}; // R18
		end
		if (rsp_valid) begin
			if (next_outstanding > {8'h00, rsp_flits}) begin
				next_outstanding = next_outstanding - {8'h00, rsp_flits}; // R18
			end else begin
				next_outstanding = rfl_pkg::RST_CNT;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			outstanding <= rfl_pkg::RST_CNT;
		end else begin
			outstanding <= next_outstanding;
		end
	end

	// ****************
	// Interrupt status
	// ****************
	assign events[rfl_pkg::ST_RSPQ_UNCORR-rfl_pkg::ST_LSB] =
		rspq_ecc_uncorr; // R11
	assign events[rfl_pkg::ST_RSPQ_CORR-rfl_pkg::ST_LSB] = rspq_ecc_corr; // R12
	assign events[rfl_pkg::ST_FERR-rfl_pkg::ST_LSB] = !mem_fatal_n; // R13
	assign events[rfl_pkg::ST_RTRY_UNCORR-rfl_pkg::ST_LSB] =
		rtry_ecc_uncorr; // R14
	assign events[rfl_pkg::ST_RTRY_CORR-rfl_pkg::ST_LSB] = rtry_ecc_corr; // R15

	always_comb begin
		clr_mask = '0;
		if (wr_status || wr_clr) begin
			clr_mask = reg_wdata[rfl_pkg::ST_RSPQ_UNCORR:rfl_pkg::ST_LSB]; // R10
		end
	end

	// Per bit: set beats clear; ECC bits dead without option
	genvar gi;
	generate
		for (gi = 0; gi < rfl_pkg::ST_W; gi++) begin : g_status
			always_comb begin
				next_status[gi] = status[gi] && !clr_mask[gi]; // R10
				if (events[gi] && (ECC_EN || !rfl_pkg::ST_ECC_MASK[gi])) begin
					next_status[gi] = 1'b1; // R16
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!nrst) begin
			status <= rfl_pkg::RST_STATUS;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_en <= rfl_pkg::RST_IRQ_EN;
			global_en <= rfl_pkg::RST_GLOBAL_EN;
		end else if (reg_wr && (reg_addr == rfl_pkg::ADDR_IRQ_EN)) begin
			irq_en <= reg_wdata[rfl_pkg::ST_RSPQ_UNCORR:rfl_pkg::ST_LSB];
		end else if (reg_wr && (reg_addr == rfl_pkg::ADDR_GLOBAL_EN)) begin
			global_en <= reg_wdata[0];
		end
	end

	assign irq = global_en && |(status & irq_en); // R8 R9

	// ****************
	// Read port
	// ****************
	always_ff @(posedge clock) begin
		if (!nrst) begin
			reg_rdata <= rfl_pkg::RD_ZERO;
		end else if (!reg_rd) begin
			reg_rdata <= rfl_pkg::RD_ZERO;
		end else begin
			reg_rdata <= rfl_pkg::RD_ZERO;
			unique case (reg_addr)
				rfl_pkg::ADDR_LIMIT: begin
					if (FULL_WIDTH) begin // R7
						reg_rdata[rfl_pkg::LIMIT_EN_BIT] <= limit_en;
						reg_rdata[rfl_pkg::THR_MSB:rfl_pkg::THR_LSB] <= thr_field;
					end
				end
				rfl_pkg::ADDR_STATUS: begin
					reg_rdata[rfl_pkg::ST_RSPQ_UNCORR:rfl_pkg::ST_LSB] <= status;
				end
				rfl_pkg::ADDR_IRQ_EN: begin
					reg_rdata[rfl_pkg::ST_RSPQ_UNCORR:rfl_pkg::ST_LSB] <= irq_en;
				end
				rfl_pkg::ADDR_GLOBAL_EN: begin
					reg_rdata[0] <= global_en;
				end
				rfl_pkg::ADDR_OUTSTANDING: begin
					reg_rdata[rfl_pkg::CNT_W-1:0] <= outstanding;
				end
				default: begin
					reg_rdata <= rfl_pkg::RD_ZERO;
				end
			endcase
		end
	end

	// ****************
	// Checks
	// ****************
	property p_limit_block;
		@(posedge clock) disable iff (!nrst)
		(limit_en && (projected > threshold)) |-> !request_port_ready;
	endproperty
	a_limit_block: assert property (p_limit_block) // R1
		else $error("request passed over the FLIT limit");

	property p_threshold;
		@(posedge clock) disable iff (!nrst)
		wr_limit |=> (threshold ==
			{2'b00, $past(reg_wdata[rfl_pkg::THR_MSB:rfl_pkg::THR_LSB]), 2'b00});
	endproperty
	a_threshold: assert property (p_threshold) // R2
		else $error("threshold not four times field");

	property p_resources;
		@(posedge clock) disable iff (!nrst)
		request_port_ready |-> (retry_space_ok && token_ok);
	endproperty
	a_resources: assert property (p_resources) // R3
		else $error("ready without retry space or tokens");

	property p_half_width;
		@(posedge clock) disable iff (!nrst)
		(!FULL_WIDTH && reg_rd && reg_addr == rfl_pkg::ADDR_LIMIT)
		|=> (reg_rdata == rfl_pkg::RD_ZERO);
	endproperty
	a_half_width: assert property (p_half_width) // R7
		else $error("limiter register visible in half width");

	property p_irq_src;
		@(posedge clock) disable iff (!nrst)
		(global_en && |(status & irq_en)) |-> irq;
	endproperty
	a_irq_src: assert property (p_irq_src) // R8
		else $error("enabled source did not raise irq");

	property p_irq_global;
		@(posedge clock) disable iff (!nrst)
		!global_en |-> !irq;
	endproperty
	a_irq_global: assert property (p_irq_global) // R9
		else $error("irq raised with global enable off");

	property p_w1c;
		@(posedge clock) disable iff (!nrst)
		(wr_status && reg_wdata[15] && !rspq_ecc_uncorr) |=> !status[4];
	endproperty
	a_w1c: assert property (p_w1c) // R10
		else $error("write one did not clear status");

	property p_fatal;
		@(posedge clock) disable iff (!nrst)
		!mem_fatal_n |=> status[2] [*1];
	endproperty
	a_fatal: assert property (p_fatal) // R13
		else $error("fatal pin did not set status");

	property p_ecc_off;
		@(posedge clock) disable iff (!nrst)
		!ECC_EN |-> ((status & rfl_pkg::ST_ECC_MASK) == 5'h00);
	endproperty
	a_ecc_off: assert property (p_ecc_off) // R16
		else $error("ECC status set without ECC option");

	property p_reset_limit;
		@(posedge clock)
		!nrst |=> (!limit_en && thr_field == rfl_pkg::RST_THR);
	endproperty
	a_reset_limit: assert property (p_reset_limit) // R17
		else $error("limiter not cleared by reset");

	property p_count;
		@(posedge clock) disable iff (!nrst)
		(req_sent && !rsp_valid) |=>
			(outstanding == $past(outstanding) + {8'h00, $past(req_rsp_flits)});
	endproperty
	a_count: assert property (p_count) // R18
		else $error("outstanding count not raised by request");

	property p_count_rsp;
		@(posedge clock) disable iff (!nrst)
		(rsp_valid && !req_sent && outstanding >= {8'h00, rsp_flits})
		|=> (outstanding == $past(outstanding) - {8'h00, $past(rsp_flits)});
	endproperty
	a_count_rsp: assert property (p_count_rsp) // R18
		else $error("outstanding count not lowered by response");

	property p_backpressure;
		@(posedge clock) disable iff (!nrst)
		(!retry_space_ok || !token_ok || over_limit) |-> !request_port_ready;
	endproperty
	a_backpressure: assert property (p_backpressure) // R5
		else $error("ready high while request must be held");

	property p_ready_free;
		@(posedge clock) disable iff (!nrst)
		(!limit_en && retry_space_ok && token_ok) |-> request_port_ready;
	endproperty
	a_ready_free: assert property (p_ready_free) // R3
		else $error("ready low with resources and limiter off");

	property p_rspq_uncorr;
		@(posedge clock) disable iff (!nrst)
		(ECC_EN && rspq_ecc_uncorr)
		|=> status[rfl_pkg::ST_RSPQ_UNCORR-rfl_pkg::ST_LSB];
	endproperty
	a_rspq_uncorr: assert property (p_rspq_uncorr) // R11
		else $error("response queue uncorrectable flag not set");

	property p_rspq_corr;
		@(posedge clock) disable iff (!nrst)
		(ECC_EN && rspq_ecc_corr)
		|=> status[rfl_pkg::ST_RSPQ_CORR-rfl_pkg::ST_LSB];
	endproperty
	a_rspq_corr: assert property (p_rspq_corr) // R12
		else $error("response queue correctable flag not set");

	property p_rtry_uncorr;
		@(posedge clock) disable iff (!nrst)
		(ECC_EN && rtry_ecc_uncorr)
		|=> status[rfl_pkg::ST_RTRY_UNCORR-rfl_pkg::ST_LSB];
	endproperty
	a_rtry_uncorr: assert property (p_rtry_uncorr) // R14
		else $error("retry buffer uncorrectable flag not set");

	property p_rtry_corr;
		@(posedge clock) disable iff (!nrst)
		(ECC_EN && rtry_ecc_corr)
		|=> status[rfl_pkg::ST_RTRY_CORR-rfl_pkg::ST_LSB];
	endproperty
	a_rtry_corr: assert property (p_rtry_corr) // R15
		else $error("retry buffer correctable flag not set");

	property p_clr_alias;
		@(posedge clock) disable iff (!nrst)
		(wr_clr && reg_wdata[rfl_pkg::ST_RTRY_UNCORR] && !rtry_ecc_uncorr)
		|=> !status[rfl_pkg::ST_RTRY_UNCORR-rfl_pkg::ST_LSB];
	endproperty
	a_clr_alias: assert property (p_clr_alias) // R10
		else $error("clear register did not clear status");

	property p_rd_status;
		@(posedge clock) disable iff (!nrst)
		(reg_rd && reg_addr == rfl_pkg::ADDR_STATUS)
		|=> (reg_rdata[rfl_pkg::ST_RSPQ_UNCORR:rfl_pkg::ST_LSB] == $past(status));
	endproperty
	a_rd_status: assert property (p_rd_status) // R10
		else $error("status read data wrong");

	property p_irq_quiet;
		@(posedge clock) disable iff (!nrst)
		!(|(status & irq_en)) |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) // R8
		else $error("irq raised with no enabled source");

	property p_reset_irq;
		@(posedge clock)
		!nrst |=> !irq;
	endproperty
	a_reset_irq: assert property (p_reset_irq) // R9
		else $error("irq raised after reset");

	c_blocked: cover property (@(posedge clock) disable iff (!nrst)
		req_valid && over_limit);
	c_irq: cover property (@(posedge clock) disable iff (!nrst)
		$rose(irq));
	c_clear: cover property (@(posedge clock) disable iff (!nrst)
		irq ##1 wr_status ##1 !irq);
	c_limited_pass: cover property (@(posedge clock) disable iff (!nrst)
		limit_en && req_sent);
	c_set_wins: cover property (@(posedge clock) disable iff (!nrst)
		wr_status && !mem_fatal_n && reg_wdata[rfl_pkg::ST_FERR]);
endmodule
`default_nettype wire

// *** rfl_pkg.sv ***
// Summary of operation
// [R1] Limiter on: hold requests that push outstanding FLITs over threshold.
// [R2] Threshold equals four times the limiter field in bits 9 down to 2.
// [R3] Send requests only while retry buffer space and flow tokens exist.
// [R4] Client requests only when it can take the response at any time.
// [R5] Backpressure a request by driving request_port_ready low.
// [R6] Software sets the field near 150; lower cuts latency and throughput.
// [R7] Limiter register at 0x1C exists only in full-width builds.
// [R8] A source's enable bit lets its status raise irq, under global enable.
// [R9] Global enable off keeps irq low; on lets enabled sources drive it.
// [R10] Writing 1 to a status bit clears it; writing 0 leaves it.
// [R11] Uncorrectable response queue ECC error sets status bit 15.
// [R12] Correctable response queue ECC error sets bit 14 and is corrected.
// [R13] Low fatal-error input from memory sets status bit 13.
// [R14] Uncorrectable retry buffer ECC error sets status bit 12.
// [R15] Correctable retry buffer ECC error sets bit 11 and is corrected.
// [R16] ECC status bits 11, 12, 14, 15 work only with the ECC build option.
// [R17] Limiter enable and threshold field read zero after reset.
// [R18] Count outstanding FLITs: add on request sent, subtract on response.
`default_nettype none
package rfl_pkg;
	// ****************
	// Register map
	// ****************
	localparam logic [7:0] ADDR_LIMIT = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
	localparam logic [7:0] ADDR_GLOBAL_EN = 8'h28;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h2C;
	localparam logic [7:0] ADDR_OUTSTANDING = 8'h30;
	// ****************
	// Fields
	// ****************
	localparam int LIMIT_EN_BIT = 31;
	localparam int THR_LSB = 2;
	localparam int THR_MSB = 9;
	localparam int THR_W = 8;
	localparam int CNT_W = 12;
	localparam int LEN_W = 4;
	localparam int ST_RSPQ_UNCORR = 15;
	localparam int ST_RSPQ_CORR = 14;
	localparam int ST_FERR = 13;
	localparam int ST_RTRY_UNCORR = 12;
	localparam int ST_RTRY_CORR = 11;
	localparam int ST_LSB = 11;
	localparam int ST_W = 5;
	localparam logic [4:0] ST_ECC_MASK = 5'h1B;
	// ****************
	// Reset values
	// ****************
	localparam logic RST_LIMIT_EN = 1'b0;
	localparam logic [7:0] RST_THR = 8'h00;
	localparam logic [4:0] RST_STATUS = 5'h00;
	localparam logic [4:0] RST_IRQ_EN = 5'h00;
	localparam logic RST_GLOBAL_EN = 1'b0;
	localparam logic [11:0] RST_CNT = 12'h000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// *** rfl_partner.sv ***
`default_nettype none
module rfl_partner (
	input wire logic clock,
	input wire logic nrst,
	input wire logic go,
	input wire logic rsp_en,
	input wire logic [3:0] len,
	input wire logic request_port_ready,
	output logic req_valid,
	output logic [3:0] req_rsp_flits,
	output logic rsp_valid,
	output logic [3:0] rsp_flits,
	output logic [11:0] owed
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************
	// Client and memory
	// ****************
	logic [11:0] next_owed;
	assign req_valid = go;
	assign req_rsp_flits = len;
	// Memory returns at most 3 FLITs a beat, client always takes them
	assign rsp_valid = rsp_en && owed != 12'h000;
	assign rsp_flits = owed > 12'h003 ? 4'h3 : owed[3:0];
	always_comb begin
		next_owed = owed;
		if (req_valid && request_port_ready)
			next_owed = next_owed + 12'(req_rsp_flits);
		if (rsp_valid)
			next_owed = next_owed - 12'(rsp_flits);
	end
	always_ff @(posedge clock) begin
		owed <= nrst ? next_owed : 12'h000;
	end
endmodule
`default_nettype wire

// *** rfl_ctrl_tb.sv ***
`default_nettype none
module rfl_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic go = 1'b0, rsp_en = 1'b0, retry_ok = 1'b1, tok_ok = 1'b1;
	logic chk_on = 1'b0, rnd_on = 1'b0, lim_en = 1'b0;
	logic ready, irq, rsp_valid, req_valid;
	logic [7:0] reg_addr = 8'h00, field = 8'h00, ca;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
	logic [3:0] len = 4'h0, req_len, rsp_len;
	logic [4:0] ev = 5'h00;
	logic [11:0] owed;
	int seed = 54305, err_count = 0, total_checks = 0;
	always #12.5 clock = ~clock;
	rfl_ctrl rfl_ctrl_inst (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .req_valid(req_valid), .req_rsp_flits(req_len),
		.request_port_ready(ready), .retry_space_ok(retry_ok),
		.token_ok(tok_ok), .rsp_valid(rsp_valid), .rsp_flits(rsp_len),
		.rspq_ecc_uncorr(ev[4]), .rspq_ecc_corr(ev[3]),
		.rtry_ecc_uncorr(ev[1]), .rtry_ecc_corr(ev[0]),
		.mem_fatal_n(~ev[2]), .irq(irq));
	rfl_partner rfl_partner_inst (.clock(clock), .nrst(nrst), .go(go),
		.rsp_en(rsp_en), .len(len), .request_port_ready(ready),
		.req_valid(req_valid), .req_rsp_flits(req_len), .rsp_valid(rsp_valid),
		.rsp_flits(rsp_len), .owed(owed));
	// ****************
	// Checking helpers
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, e);
	endtask
	function automatic logic exp_ready();
		exp_ready = retry_ok && tok_ok &&
			!(lim_en && int'(owed) + int'(len) > 4 * int'(field));
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(negedge clock) begin
		if (chk_on)
			chk(32'(ready), 32'(exp_ready()));
	end
	always @(posedge clock) begin
		if (rnd_on) begin
			rv = $random(seed);
			go <= rv[0];
			rsp_en <= rv[1];
			retry_ok <= rv[2] | rv[3];
			tok_ok <= rv[4] | rv[5];
			len <= rv[11:8];
		end else begin
			go <= 1'b0;
			rsp_en <= 1'b0;
		end
	end
	initial begin
		#100000;
		err_count++;
		summarize();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		for (int a = 32'h0000_001C; a < 32'h0000_0038; a += 4)
			rdc(8'(a), 32'h0000_0000);
		wr(rfl_pkg::ADDR_LIMIT, 32'hFFFF_FFFF);
		rdc(rfl_pkg::ADDR_LIMIT, 32'h8000_03FC);
		$display("test reset and map done");
		for (int ph = 0; ph < 3; ph++) begin
			lim_en = ph != 0;
			field = ph == 1 ? 8'h02 : 8'h96;
			wr(rfl_pkg::ADDR_LIMIT, {lim_en, 21'h00_0000, field, 2'h0});
			rdc(rfl_pkg::ADDR_LIMIT, {lim_en, 21'h00_0000, field, 2'h0});
			chk_on = 1'b1;
			rnd_on = 1'b1;
			repeat (400) @(posedge clock);
			@(negedge clock);
			rnd_on = 1'b0;
			chk_on = 1'b0;
			@(posedge clock);
			@(negedge clock);
			rdc(rfl_pkg::ADDR_OUTSTANDING, 32'(owed));
			$display("test limiter phase %0d done", ph);
		end
		wr(rfl_pkg::ADDR_IRQ_EN, 32'h0000_F800);
		for (int i = 0; i < 5; i++) begin
			ca = i[0] ? rfl_pkg::ADDR_IRQ_CLR : rfl_pkg::ADDR_STATUS;
			@(posedge clock);
			ev <= 5'h01 << i;
			@(posedge clock);
			ev <= 5'h00;
			wr(rfl_pkg::ADDR_GLOBAL_EN, 32'h0000_0000);
			rdc(rfl_pkg::ADDR_STATUS, 32'h0000_0800 << i);
			chk(32'(irq), 32'h0000_0000);
			wr(rfl_pkg::ADDR_GLOBAL_EN, 32'h0000_0001);
			@(negedge clock);
			chk(32'(irq), 32'h0000_0001);
			wr(rfl_pkg::ADDR_IRQ_EN, 32'h0000_F800 ^ (32'h0000_0800 << i));
			@(negedge clock);
			chk(32'(irq), 32'h0000_0000);
			wr(rfl_pkg::ADDR_IRQ_EN, 32'h0000_F800);
			wr(ca, ~(32'h0000_0800 << i));
			rdc(rfl_pkg::ADDR_STATUS, 32'h0000_0800 << i);
			chk(32'(irq), 32'h0000_0001);
			wr(ca, 32'h0000_0800 << i);
			rdc(rfl_pkg::ADDR_STATUS, 32'h0000_0000);
			chk(32'(irq), 32'h0000_0000);
		end
		// Fatal pin low in the same cycle as its clear: set wins
		@(posedge clock);
		ev <= 5'h04;
		reg_wr <= 1'b1;
		reg_addr <= rfl_pkg::ADDR_STATUS;
		reg_wdata <= 32'h0000_2000;
		@(posedge clock);
		ev <= 5'h00;
		reg_wr <= 1'b0;
		rdc(rfl_pkg::ADDR_STATUS, 32'h0000_2000);
		chk(32'(irq), 32'h0000_0001);
		wr(rfl_pkg::ADDR_STATUS, 32'h0000_2000);
		rdc(rfl_pkg::ADDR_STATUS, 32'h0000_0000);
		$display("test interrupts done");
		summarize();
	end
endmodule
`default_nettype wire
